// ### logic/mgmt_host.sv
`timescale 1ns/1ps
`include "mcs_params.svh"
module mgmt_host #(
  parameter int unsigned WR_WAIT_CYC = `WR4_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // link to the module
  mgmt_link_if.host_mp     link
);
  localparam logic [31:0] HALF = 32'(`SCL_HALF_CYC);

  mcs_pkg::host_state_t q;
  mcs_pkg::host_state_t d;
  logic [3:0]           in_s;
  logic                 scl_s;
  logic                 sda_s;
  logic                 fault_s;
  logic                 los_s;
  logic                 access;
  logic                 take;
  logic                 tick;
  logic                 tx_byte;
  logic [6:0]           dev;
  logic [31:0]          hold_lim;

  sync2 #(.W(4)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.scl, link.sda, link.fault, link.receive_signal_lost}),
    .q_o   (in_s)
  );
  assign {scl_s, sda_s, fault_s, los_s} = in_s;

  // ================================================================
  // next state
  always_comb begin
    d        = q;
    access   = psel_i & penable_i & ~q.pready;
    take     = psel_i & penable_i & q.pready;
    tick     = q.cnt == HALF - 32'd1;
    tx_byte  = q.bidx != 2'd3;
    dev      = q.diag ? `DEV_DIAG_ADDR : `DEV_ID_ADDR;
    // never shorter than the bus buffer time, even with a short write wait
    hold_lim = 32'(`BUF_CYC);
    if (!q.rd && !q.nack && WR_WAIT_CYC > 32'(`BUF_CYC)) begin
      hold_lim = WR_WAIT_CYC;
    end
    d.pready = access;

    // apb: answer one cycle into the access phase, act when taken
    if (access) begin
      d.prdata  = 32'h0;
      d.pslverr = 1'b0;
      case (paddr_i)
        `HR_CTRL:   d.prdata = {8'h00, q.wdata, q.maddr, 5'h00, q.diag, q.rd, 1'b0};
        `HR_PINS:   d.prdata = {30'h0, q.rate_pin, q.sw_txoff};
        `HR_STATUS: d.prdata = {16'h0, q.rdata, 4'h0, los_s, fault_s, q.nack,
                                q.st != mcs_pkg::H_IDLE};
        default:    d.pslverr = 1'b1;
      endcase
    end
    if (take && pwrite_i) begin
      if (paddr_i == `HR_CTRL && pwdata_i[`CF_GO] && q.st == mcs_pkg::H_IDLE) begin
        d.rd    = pwdata_i[`CF_RD];
        d.diag  = pwdata_i[`CF_DIAG];
        d.maddr = pwdata_i[`CF_ADDR_LSB +: 8];
        d.wdata = pwdata_i[`CF_WDATA_LSB +: 8];
        d.sh    = {(pwdata_i[`CF_DIAG] ? `DEV_DIAG_ADDR : `DEV_ID_ADDR), 1'b0};
        d.nack  = 1'b0;
        d.bidx  = 2'd0;
        d.ph    = 2'd0;
        d.cnt   = 32'h0;
        d.st    = mcs_pkg::H_START;
      end
      if (paddr_i == `HR_PINS) begin
        d.sw_txoff = pwdata_i[`PF_TXOFF];
        d.rate_pin = pwdata_i[`PF_RATE];
      end
    end

    // transmit-off pin stays high for the reset hold once raised
    d.txoff_pin = q.sw_txoff | (q.txoff_pin & q.off_cnt != 16'(`RESET_CYC));
    if (!q.txoff_pin) begin
      d.off_cnt = 16'h0;
    end else if (q.off_cnt != 16'(`RESET_CYC)) begin
      d.off_cnt = q.off_cnt + 16'd1;
    end

    // bus engine; the clock is this side's divider
    d.cnt = q.cnt + 32'd1;
    unique case (q.st)
      mcs_pkg::H_IDLE: begin
        d.cnt = 32'h0;
      end
      mcs_pkg::H_START: begin
        unique case (q.ph)
          2'd0: begin
            d.scl_oe = 1'b1;
            d.sda_oe = 1'b0;
            if (tick) begin
              d.scl_oe = 1'b0;
              d.ph     = 2'd1;
              d.cnt    = 32'h0;
            end
          end
          2'd1: begin
            if (!scl_s) begin
              d.cnt = 32'h0;
            end else if (tick) begin
              d.sda_oe = 1'b1;
              d.ph     = 2'd2;
              d.cnt    = 32'h0;
            end
          end
          default: begin
            if (tick) begin
              d.scl_oe = 1'b1;
              d.sda_oe = ~q.sh[7];
              d.bcnt   = 4'h0;
              d.ph     = 2'd0;
              d.cnt    = 32'h0;
              d.st     = mcs_pkg::H_BIT;
            end
          end
        endcase
      end
      mcs_pkg::H_BIT: begin
        if (q.ph == 2'd0) begin
          if (tick) begin
            d.scl_oe = 1'b0;
            d.ph     = 2'd1;
            d.cnt    = 32'h0;
          end
        end else if (!scl_s) begin
          d.cnt = 32'h0;
        end else if (tick) begin
          d.scl_oe = 1'b1;
          d.ph     = 2'd0;
          d.cnt    = 32'h0;
          d.sh     = {q.sh[6:0], sda_s};
          if (q.bcnt != 4'd8) begin
            d.bcnt   = q.bcnt + 4'd1;
            d.sda_oe = (q.bcnt != 4'd7) & tx_byte & ~q.sh[6];
          end else if (tx_byte && sda_s) begin
            d.nack   = 1'b1;
            d.sda_oe = 1'b1;
            d.st     = mcs_pkg::H_STOP;
          end else begin
            d.bcnt = 4'h0;
            unique case (q.bidx)
              2'd0: begin
                d.sh     = q.maddr;
                d.sda_oe = ~q.maddr[7];
                d.bidx   = 2'd1;
              end
              2'd1: begin
                if (q.rd) begin
                  d.sh     = {dev, 1'b1};
                  d.sda_oe = 1'b0;
                  d.bidx   = 2'd2;
                  d.st     = mcs_pkg::H_START;
                end else begin
                  d.sh     = q.wdata;
                  d.sda_oe = ~q.wdata[7];
                  d.bidx   = 2'd2;
                end
              end
              2'd2: begin
                d.sda_oe = ~q.rd;
                d.bidx   = 2'd3;
                if (!q.rd) begin
                  d.st = mcs_pkg::H_STOP;
                end
              end
              default: begin
                d.rdata  = q.sh;
                d.sda_oe = 1'b1;
                d.st     = mcs_pkg::H_STOP;
              end
            endcase
          end
        end
      end
      mcs_pkg::H_STOP: begin
        if (q.ph == 2'd0) begin
          if (tick) begin
            d.scl_oe = 1'b0;
            d.ph     = 2'd1;
            d.cnt    = 32'h0;
          end
        end else if (!scl_s) begin
          d.cnt = 32'h0;
        end else if (tick) begin
          d.sda_oe = 1'b0;
          d.ph     = 2'd0;
          d.cnt    = 32'h0;
          d.st     = mcs_pkg::H_HOLD;
        end
      end
      default: begin
        if (q.cnt >= hold_lim - 32'd1) begin
          d.st = mcs_pkg::H_IDLE;
        end
      end
    endcase
  end

  // ================================================================
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata_o         = q.prdata;
  assign pready_o         = q.pready;
  assign pslverr_o        = q.pslverr;
  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = q.scl_oe;
  assign link.host_sda_oe = q.sda_oe;
  assign link.tx_off      = q.txoff_pin;
  assign link.rate_sel    = q.rate_pin;
endmodule // mgmt_host

// ### pkg/mcs_params.svh
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// ==================================================================
// clock
`define CLK_MHZ          100

// ==================================================================
// module timing, in the unit printed
`define T_INIT_MS        300
`define T_RESET_US       10
`define T_DATA_MS        1000
`define T_BUF_US         20
`define T_WR4_MS         40
`define T_WR8_MS         80
`define F_SCL_KHZ        400

// ==================================================================
// derived cycle counts
`define RESET_CYC        (`T_RESET_US * `CLK_MHZ)
`define BUF_CYC          (`T_BUF_US * `CLK_MHZ)
// half the init budget, leaving margin for the laser settle delay
`define INIT_CYC         (`T_INIT_MS * 1000 * `CLK_MHZ / 2)
`define DATA_CYC         (`T_DATA_MS * 1000 * `CLK_MHZ)
`define WR4_CYC          (`T_WR4_MS * 1000 * `CLK_MHZ)
`define WR8_CYC          (`T_WR8_MS * 1000 * `CLK_MHZ)
// least half period of the bus clock, rounded up
`define SCL_HALF_CYC     ((`CLK_MHZ * 1000 + 2 * `F_SCL_KHZ - 1) / (2 * `F_SCL_KHZ))
// module clock hold after each acknowledge the module gives, far below the 500 us limit
`define STRETCH_CYC      32
// laser settle delay after the disable goes away
`define ON_DELAY_CYC     200
`define WR_SPLIT_BYTES   4

// ==================================================================
// bus addresses and the status/control byte
`define DEV_ID_ADDR      7'h50
`define DEV_DIAG_ADDR    7'h51
`define STATUS_BYTE      8'h6E
`define STATUS_RESET     8'h00
`define SB_TXOFF_HW      7
`define SB_TXOFF_SW      6
`define SB_RATE          4
`define SB_FAULT         2
`define SB_LOS           1
`define SB_READY         0

// ==================================================================
// host controller registers
`define HR_CTRL          8'h00
`define HR_PINS          8'h04
`define HR_STATUS        8'h08
`define CF_GO            0
`define CF_RD            1
`define CF_DIAG          2
`define CF_ADDR_LSB      8
`define CF_WDATA_LSB     16
`define PF_TXOFF         0
`define PF_RATE          1
`define SF_BUSY          0
`define SF_NACK          1
`define SF_FAULT         2
`define SF_LOS           3
`define SF_RDATA_LSB     8

`endif

// ### pkg/mcs_pkg.sv
package mcs_pkg;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_RXEND, S_ACK, S_TX, S_TXACK} dev_st_t;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} kind_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_HOLD} host_st_t;

  typedef struct packed {
    dev_st_t     st;
    kind_t       kind;
    logic [2:0]  bcnt;
    logic [7:0]  sh;
    logic        sel;
    logic        rd;
    logic [7:0]  ptr;
    logic [3:0]  wcnt;
    logic        scl_p;
    logic        sda_p;
    logic [15:0] stretch;
    logic [31:0] busy_cnt;
    logic [31:0] por_cnt;
    logic        ser_rdy;
    logic        mon_rdy;
    logic        soft_off;
    logic        fault;
    logic [15:0] off_cnt;
    logic [15:0] on_cnt;
    logic        laser_on;
    logic        rate;
    logic        los;
    logic        scl_oe;
    logic        sda_oe;
  } dev_state_t;

  typedef struct packed {
    host_st_t    st;
    logic [1:0]  ph;
    logic [31:0] cnt;
    logic [3:0]  bcnt;
    logic [1:0]  bidx;
    logic [7:0]  sh;
    logic        rd;
    logic        diag;
    logic [7:0]  maddr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        nack;
    logic        scl_oe;
    logic        sda_oe;
    logic        sw_txoff;
    logic        txoff_pin;
    logic [15:0] off_cnt;
    logic        rate_pin;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } host_state_t;

endpackage

// ### pkg/mgmt_link_if.sv
`timescale 1ns/1ps
interface mgmt_link_if;
  // open-drain bus: each party drives low only while its enable is high
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // side-band pins
  logic tx_off;
  logic rate_sel;
  logic fault;
  logic receive_signal_lost;

  assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host_mp (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, tx_off, rate_sel,
                   input  scl, sda, fault, receive_signal_lost);
  modport dev_mp  (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, fault,
                          receive_signal_lost,
                   input  scl, sda, tx_off, rate_sel);
endinterface

// ### logic/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d_i,
  output logic [W-1:0]      q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // sync2

// ### logic/optic_module.sv
// Operation
// - raised transmit-off pin kills light within 10 us
// - lowered transmit-off restores light within 1 ms
// - init, fault clear, light on within 300 ms
// - laser fault pin asserts within 100 us
// - host holds transmit-off 10 us to clear fault
// - signal-lost pin follows input within 100 us
// - rate change completes within 10 us
// - software transmit-off bit acts within 100 ms
// - software fault bit sets within 100 ms
// - software signal-lost bit tracks within 100 ms
// - monitor-ready bit set within 1000 ms
// - bus answers both addresses within 300 ms
// - host keeps 20 us bus buffer time
// - write completes in 40 or 80 ms
// - module may stretch clock up to 500 us
// - host bus clock at most 400 kHz
`timescale 1ns/1ps
`include "mcs_params.svh"
module optic_module #(
  parameter int unsigned INIT_CYC = `INIT_CYC,
  parameter int unsigned DATA_CYC = `DATA_CYC,
  parameter int unsigned WR4_CYC  = `WR4_CYC,
  parameter int unsigned WR8_CYC  = `WR8_CYC
) (
  // clock and reset
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  // link to the host
  mgmt_link_if.dev_mp  link,
  // optical side
  input  wire logic    laser_fault_i,
  input  wire logic    signal_ok_i,
  output logic         laser_on_o,
  output logic         rate_high_o
);
  mcs_pkg::dev_state_t q;
  mcs_pkg::dev_state_t d;
  logic [5:0]          in_s;
  logic                scl_s;
  logic                sda_s;
  logic                txoff_s;
  logic                rate_s;
  logic                fault_s;
  logic                sig_lost_s;  // carried inverted so a reset sync reads as no loss
  logic [7:0]          mem [512];
  logic                mem_we;
  logic [8:0]          mem_wa;
  logic [7:0]          mem_wd;
  logic [7:0]          status;
  logic [7:0]          rd_byte;
  logic                rise;
  logic                fall;
  logic                start;
  logic                stop;
  logic                laser_off;

  // ================================================================
  // input synchronisers
  sync2 #(.W(6)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.scl, link.sda, link.tx_off, link.rate_sel, laser_fault_i, ~signal_ok_i}),
    .q_o   (in_s)
  );
  assign {scl_s, sda_s, txoff_s, rate_s, fault_s, sig_lost_s} = in_s;

  // ================================================================
  // status/control byte and read data
  always_comb begin
    status                = `STATUS_RESET;
    status[`SB_TXOFF_HW]  = txoff_s;
    status[`SB_TXOFF_SW]  = q.soft_off;
    status[`SB_RATE]      = q.rate;
    status[`SB_FAULT]     = q.fault;
    status[`SB_LOS]       = q.los;
    status[`SB_READY]     = q.mon_rdy;
    rd_byte = (q.sel && q.ptr == `STATUS_BYTE) ? status : mem[{q.sel, q.ptr}];
  end

  // ================================================================
  // next state
  always_comb begin
    d      = q;
    mem_we = 1'b0;
    mem_wa = {q.sel, q.ptr};
    mem_wd = q.sh;
    rise   = scl_s & ~q.scl_p;
    fall   = ~scl_s & q.scl_p;
    start  = scl_s & q.scl_p & q.sda_p & ~sda_s;
    stop   = scl_s & q.scl_p & ~q.sda_p & sda_s;
    d.scl_p = scl_s;
    d.sda_p = sda_s;

    // power-on readiness
    if (q.por_cnt != DATA_CYC) begin
      d.por_cnt = q.por_cnt + 32'd1;
    end
    d.ser_rdy = q.ser_rdy | (q.por_cnt == INIT_CYC);
    d.mon_rdy = q.mon_rdy | (q.por_cnt == DATA_CYC - 32'd1);
    if (q.busy_cnt != 32'h0) begin
      d.busy_cnt = q.busy_cnt - 32'd1;
    end
    if (q.stretch != 16'h0) begin
      d.stretch = q.stretch - 16'd1;
    end

    // two-wire slave
    if (start) begin
      d.st     = mcs_pkg::S_RX;
      d.kind   = mcs_pkg::K_ADDR;
      d.bcnt   = 3'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      if (q.wcnt != 4'h0) begin
        // writes count from the stop; address is refused until done
        d.busy_cnt = (q.wcnt > 4'(`WR_SPLIT_BYTES)) ? WR8_CYC : WR4_CYC;
      end
      d.wcnt   = 4'h0;
      d.st     = mcs_pkg::S_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        mcs_pkg::S_IDLE: begin
        end
        mcs_pkg::S_RX: begin
          if (rise) begin
            d.sh   = {q.sh[6:0], sda_s};
            d.bcnt = q.bcnt + 3'd1;
            if (q.bcnt == 3'd7) begin
              d.st = mcs_pkg::S_RXEND;
            end
          end
        end
        mcs_pkg::S_RXEND: begin
          if (fall) begin
            d.st     = mcs_pkg::S_ACK;
            d.sda_oe = 1'b1;
            unique case (q.kind)
              mcs_pkg::K_ADDR: begin
                if ((q.sh[7:1] | 7'h01) == `DEV_DIAG_ADDR && q.ser_rdy
                    && q.busy_cnt == 32'h0) begin
                  d.sel  = q.sh[1];
                  d.rd   = q.sh[0];
                  d.kind = q.sh[0] ? mcs_pkg::K_DATA : mcs_pkg::K_PTR;
                end else begin
                  d.st     = mcs_pkg::S_IDLE;
                  d.sda_oe = 1'b0;
                end
              end
              mcs_pkg::K_PTR: begin
                d.ptr  = q.sh;
                d.kind = mcs_pkg::K_DATA;
              end
              default: begin
                if (q.sel && q.ptr == `STATUS_BYTE) begin
                  d.soft_off = q.sh[`SB_TXOFF_SW];
                end else begin
                  mem_we = 1'b1;
                end
                d.ptr = q.ptr + 8'd1;
                if (q.wcnt != 4'hF) begin
                  d.wcnt = q.wcnt + 4'd1;
                end
              end
            endcase
          end
        end
        mcs_pkg::S_ACK: begin
          if (fall) begin
            // hold the clock low briefly while the next byte is prepared
            d.stretch = 16'(`STRETCH_CYC);
            d.bcnt    = 3'h0;
            if (q.rd) begin
              d.sh     = rd_byte;
              d.sda_oe = ~rd_byte[7];
              d.st     = mcs_pkg::S_TX;
            end else begin
              d.sda_oe = 1'b0;
              d.st     = mcs_pkg::S_RX;
            end
          end
        end
        mcs_pkg::S_TX: begin
          if (fall) begin
            if (q.bcnt == 3'd7) begin
              d.sda_oe = 1'b0;
              d.ptr    = q.ptr + 8'd1;
              d.st     = mcs_pkg::S_TXACK;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.bcnt   = q.bcnt + 3'd1;
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        mcs_pkg::S_TXACK: begin
          if (rise && sda_s) begin
            d.st = mcs_pkg::S_IDLE;
          end else if (fall) begin
            d.sh     = rd_byte;
            d.bcnt   = 3'h0;
            d.sda_oe = ~rd_byte[7];
            d.st     = mcs_pkg::S_TX;
          end
        end
      endcase
    end
    d.scl_oe = d.stretch != 16'h0;

    // laser control; a fresh fault wins over the clearing hold
    if (txoff_s) begin
      if (q.off_cnt != 16'(`RESET_CYC)) begin
        d.off_cnt = q.off_cnt + 16'd1;
      end
    end else begin
      d.off_cnt = 16'h0;
    end
    d.fault = fault_s
            | (q.fault & ~(txoff_s && q.off_cnt == 16'(`RESET_CYC)));
    laser_off = txoff_s | q.soft_off | q.fault | ~q.ser_rdy;
    if (laser_off) begin
      d.laser_on = 1'b0;
      d.on_cnt   = 16'h0;
    end else if (q.on_cnt == 16'(`ON_DELAY_CYC)) begin
      d.laser_on = 1'b1;
    end else begin
      d.on_cnt = q.on_cnt + 16'd1;
    end
    d.los  = sig_lost_s;
    d.rate = rate_s;
  end

  // ================================================================
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // memory holds no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign link.dev_scl_o           = 1'b0;
  assign link.dev_sda_o           = 1'b0;
  assign link.dev_scl_oe          = q.scl_oe;
  assign link.dev_sda_oe          = q.sda_oe;
  assign link.fault               = q.fault;
  assign link.receive_signal_lost = q.los;
  assign laser_on_o               = q.laser_on;
  assign rate_high_o              = q.rate;
endmodule // optic_module

// ### sim/link_chk.sv
`timescale 1ns/1ps
// ==================
// link and pin checks
module link_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link and optical pins
  input wire logic tx_off,
  input wire logic rate_sel,
  input wire logic fault,
  input wire logic receive_signal_lost,
  input wire logic scl,
  input wire logic laser_fault_i,
  input wire logic signal_ok_i,
  input wire logic laser_on_o,
  input wire logic rate_high_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // length of the current low phase of the bus clock
  int low_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) low_q <= 0;
    else low_q <= scl ? 0 : low_q + 1;
  end
  light_off_a: assert property ($rose(tx_off) |-> ##[0:1000] !laser_on_o)
    else $error("light stays on");
  light_on_a: assert property ($fell(tx_off) && !fault && !laser_fault_i
    |-> ##[1:1000] laser_on_o) else $error("light not back");
  fault_pin_a: assert property ($rose(laser_fault_i) |-> ##[1:8] fault)
    else $error("fault pin late");
  los_set_a: assert property ($fell(signal_ok_i) |-> ##[1:8] receive_signal_lost)
    else $error("loss pin late");
  los_clr_a: assert property ($rose(signal_ok_i) |-> ##[1:8] !receive_signal_lost)
    else $error("loss pin stuck");
  rate_follow_a: assert property ($changed(rate_sel) |-> ##[1:8] rate_high_o == rate_sel)
    else $error("rate late");
  clock_hold_a: assert property (low_q < 50000)
    else $error("clock held low too long");
  bus_rate_a: assert property ($rose(scl) |-> low_q >= 124)
    else $error("bus clock low phase too short");
  no_light_a: assert property ($rose(laser_on_o) |-> !tx_off)
    else $error("light on while off");
endmodule // link_chk

// ### sim/tb.sv
`timescale 1ns/1ps
// ==================
// bench
module tb;
  localparam logic [32:0] MB = 33'h0_0000_FF02;
  localparam logic [32:0] MN = 33'h0_0000_0002;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata_o;
  logic        pready_o, pslverr_o, laser_on_o, rate_high_o;
  logic        laser_fault_i = 1'b0, signal_ok_i = 1'b1;
  logic [32:0] exp_q[$], msk_q[$];
  logic [7:0]  d;
  int          error_cnt = 0, n_checks = 0;
  always #5 clk_i = ~clk_i;
  mgmt_link_if lk ();
  mgmt_host #(.WR_WAIT_CYC(10)) mgmt_host_i (.clk_i, .rst_i, .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o, .pready_o, .pslverr_o, .link(lk));
  optic_module #(.INIT_CYC(200), .DATA_CYC(400), .WR4_CYC(300), .WR8_CYC(600))
    optic_module_i (.clk_i, .rst_i, .link(lk), .laser_fault_i, .signal_ok_i,
    .laser_on_o, .rate_high_o);
  link_chk link_chk_i (.clk_i, .rst_i, .tx_off(lk.tx_off), .rate_sel(lk.rate_sel),
    .fault(lk.fault), .receive_signal_lost(lk.receive_signal_lost), .scl(lk.scl),
    .laser_fault_i, .signal_ok_i, .laser_on_o, .rate_high_o);
  task check(input logic [32:0] s, input logic [32:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one transfer; the expectation goes to the queue before the request
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v,
           input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] cw(input logic r, g, input logic [7:0] a, v);
    return {8'h00, v, a, 5'h00, g, r, 1'b1};
  endfunction
  // start a bus operation, poll until idle, then check the final status
  task op(input logic [31:0] c, input logic [32:0] e, input logic [32:0] m);
    apb(1'b1, 8'h00, c, 33'h0, 33'h0);
    do apb(1'b0, 8'h08, 32'h0, 33'h0, 33'h0); while (rd[0] !== 1'b0);
    apb(1'b0, 8'h08, 32'h0, e, m);
  endtask
  // pready is settled by the falling edge, so the compare never races it
  always @(negedge clk_i) begin
    if (psel && penable && pready_o) begin
      check({pslverr_o, prdata_o} & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    repeat (150000) @(posedge clk_i);
    error_cnt++;
    print_verdict;
  end
  initial begin
    void'($urandom(36));
    d = 8'($urandom);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
    apb(1'b1, 8'h04, 32'h2, 33'h0, 33'h0);
    apb(1'b0, 8'h04, 32'h0, 33'h2, 33'h3);
    op(cw(1'b1, 1'b1, 8'h6E, 8'h00), {17'h0, 8'h11, 8'h00}, MB);
    op(cw(1'b0, 1'b0, 8'h10, d), 33'h0, MN);
    op(cw(1'b1, 1'b0, 8'h10, 8'h00), {17'h0, d, 8'h00}, MB);
    op(cw(1'b1, 1'b0, 8'h10, 8'h00), {17'h0, d, 8'h00}, MB);
    op(cw(1'b0, 1'b1, 8'h6E, 8'h40), 33'h0, MN);
    repeat (400) @(posedge clk_i);
    check({32'h0, laser_on_o}, 33'h0);
    op(cw(1'b1, 1'b1, 8'h6E, 8'h00), {17'h0, 8'h51, 8'h00}, MB);
    op(cw(1'b0, 1'b1, 8'h6E, 8'h00), 33'h0, MN);
    repeat (400) @(posedge clk_i);
    check({32'h0, laser_on_o}, 33'h1);
    laser_fault_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    apb(1'b0, 8'h08, 32'h0, 33'h4, 33'h4);
    op(cw(1'b1, 1'b1, 8'h6E, 8'h00), {17'h0, 8'h15, 8'h00}, MB);
    laser_fault_i <= 1'b0;
    apb(1'b1, 8'h04, 32'h3, 33'h0, 33'h0);
    repeat (1100) @(posedge clk_i);
    apb(1'b1, 8'h04, 32'h2, 33'h0, 33'h0);
    repeat (1100) @(posedge clk_i);
    apb(1'b0, 8'h08, 32'h0, 33'h0, 33'h4);
    check({32'h0, laser_on_o}, 33'h1);
    signal_ok_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    apb(1'b0, 8'h08, 32'h0, 33'h8, 33'h8);
    op(cw(1'b1, 1'b1, 8'h6E, 8'h00), {17'h0, 8'h13, 8'h00}, MB);
    signal_ok_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    apb(1'b0, 8'h08, 32'h0, 33'h0, 33'h8);
    print_verdict;
  end
endmodule // tb
